// >>> src/cmo_pkg.sv
// Shared constants and carriers for the cache maintenance decoder.
// Assumes one core clock; all ports synchronous to it.
package cmo_pkg;
  // Coprocessor register selects
  localparam logic [3:0] CMO_CRN_ID    = 4'h0;
  localparam logic [3:0] CMO_CRN_MAINT = 4'h7;
  localparam logic [3:0] CMO_CRM_1     = 4'h1;
  localparam logic [3:0] CMO_CRM_2     = 4'h2;
  localparam logic [3:0] CMO_CRM_4     = 4'h4;
  localparam logic [3:0] CMO_CRM_5     = 4'h5;
  localparam logic [3:0] CMO_CRM_6     = 4'h6;
  localparam logic [3:0] CMO_CRM_10    = 4'hA;
  localparam logic [3:0] CMO_CRM_11    = 4'hB;
  localparam logic [3:0] CMO_CRM_14    = 4'hE;
  localparam logic [2:0] CMO_OP2_ID_RSV = 3'h3;
  localparam logic [2:0] CMO_OP2_ISA_LAST = 3'h4;

  // APB register byte offsets
  localparam logic [11:0] CMO_OFS_CFG   = 12'h000;
  localparam logic [11:0] CMO_OFS_STAT  = 12'h004;
  localparam logic [11:0] CMO_OFS_LAST  = 12'h008;
  localparam logic [11:0] CMO_OFS_UNDEF = 12'h00C;

  // Config field: cache size code, 0 = 4KB .. 4 = 64KB
  localparam int         CMO_CFG_SIZE_LSB = 0;
  localparam logic [2:0] CMO_CFG_SIZE_RST = 3'h3;
  localparam logic [2:0] CMO_SIZE_MAX     = 3'h4;
  localparam logic [3:0] CMO_S_BASE       = 4'h5;

  // Whole instruction cache invalidate length
  localparam logic [7:0] CMO_ICINV_CYCLES = 8'h08;

  typedef struct packed {
    logic        write;
    logic        user;
    logic [2:0]  opc1;
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic [2:0]  opc2;
    logic [31:0] wdata;
  } cmo_req_t;

  typedef struct packed {
    logic        valid;
    logic        icache;
    logic        dcache;
    logic        pred;
    logic        clean;
    logic        inval;
    logic        whole;
    logic        setway;
    logic        coherent;
    logic        l2_bound;
    logic [1:0]  way;
    logic [8:0]  set;
    logic [26:0] line;
  } cmo_act_t;
endpackage

// >>> src/cmo_operand.sv
// Splits a transferred word into set/way and address operands.
// Assumes the size code is already clamped to the legal range.
`timescale 1ns/1ps
module cmo_operand
  import cmo_pkg::*;
(
  // Operand
  input  wire logic [31:0] wdata,
  input  wire logic [2:0]  size_code,
  // Fields
  output logic      [1:0]  way,
  output logic      [8:0]  set,
  output logic      [26:0] line,
  output logic             rsvd_nz
);
  logic [3:0] s_val;

  function automatic logic [8:0] cmo_set_mask(input logic [3:0] s);
    cmo_set_mask = 9'((10'h001 << s) - 10'h001);
  endfunction

  assign s_val = CMO_S_BASE + {1'b0, size_code};
  assign way   = wdata[31:30];
  assign set   = wdata[13:5] & cmo_set_mask(s_val);
  assign line  = wdata[31:5];
  // Reserved bits only flagged, never acted on
  assign rsvd_nz = (|wdata[4:0]) |
                   (|(wdata[29:5] & ~{16'h0000, cmo_set_mask(s_val)}));
endmodule

// >>> src/cmo_id_rom.sv
// Read-only feature identification values, registered output.
// Values are build parameters; defaults are arbitrary.
`timescale 1ns/1ps
module cmo_id_rom
  import cmo_pkg::*;
#(
  parameter logic [31:0] FEAT [8] = '{32'h0000_0011, 32'h0000_0012, 32'h0000_0013,
                                      32'h0000_0000, 32'h0000_0021, 32'h0000_0022,
                                      32'h0000_0023, 32'h0000_0024},
  parameter logic [31:0] ISA  [5] = '{32'h0000_0031, 32'h0000_0032, 32'h0000_0033,
                                      32'h0000_0034, 32'h0000_0035}
)(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Lookup
  input  wire logic        en,
  input  wire logic [3:0]  crm,
  input  wire logic [2:0]  opc2,
  output logic      [31:0] q
);
  typedef struct packed {
    logic [31:0] q;
  } cmo_rom_st_t;

  cmo_rom_st_t st;
  cmo_rom_st_t next_st;

  always_comb begin
    next_st = st;
    if (en) begin
      next_st.q = 32'h0000_0000;
      if (crm == CMO_CRM_1 && opc2 != CMO_OP2_ID_RSV) begin
        next_st.q = FEAT[opc2];
      end else if (crm == CMO_CRM_2 && opc2 <= CMO_OP2_ISA_LAST) begin
        next_st.q = ISA[opc2];
      end
      // Reserved selects fall through to zero
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;
endmodule

// >>> src/cmo_maint.sv
// Cache maintenance decoder: coprocessor transfers in, cache actions out.
// Assumes the pipeline holds a request until ready; APB slave, zero wait.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module cmo_maint
  import cmo_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Coprocessor transfer request
  input  wire logic        cp_valid,
  output logic             cp_ready,
  input  wire cmo_req_t    cp_req,
  // Address translation result, readable back
  input  wire logic [31:0] pa_result,
  // Response
  output logic             rsp_valid,
  output logic             rsp_undef,
  output logic      [31:0] rsp_rdata,
  // Cache and predictor actions
  output cmo_act_t         act,
  output logic             irq_hold
);
  typedef struct packed {
    logic [7:0]  busy_cnt;
    logic        rsp_valid;
    logic        rsp_undef;
    logic        rsp_pa;
    logic [31:0] pa_q;
    cmo_act_t    act;
    logic [2:0]  size_code;
    logic [15:0] op_count;
    logic [15:0] undef_count;
    logic [7:0]  last_sel;
  } cmo_st_t;

  cmo_st_t     st;
  cmo_st_t     next_st;
  logic        take;
  logic        is_maint;
  logic        is_id;
  logic        barrier;
  logic        pa_read;
  logic        apb_wr;
  logic        apb_hit;
  logic [1:0]  od_way;
  logic [8:0]  od_set;
  logic [26:0] od_line;
  logic        od_rsvd;
  logic [31:0] rom_q;

  cmo_operand u_operand (
    .wdata     (cp_req.wdata),
    .size_code (st.size_code),
    .way       (od_way),
    .set       (od_set),
    .line      (od_line),
    .rsvd_nz   (od_rsvd)
  );

  cmo_id_rom u_rom (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (take && is_id && !cp_req.write),
    .crm     (cp_req.crm),
    .opc2    (cp_req.opc2),
    .q       (rom_q)
  );

  // Long invalidate stalls new requests rather than queueing them
  assign cp_ready = (st.busy_cnt == 8'h00);
  assign take     = cp_valid && cp_ready;
  assign is_maint = cp_req.crn == CMO_CRN_MAINT && cp_req.opc1 == 3'h0;
  assign is_id    = cp_req.crn == CMO_CRN_ID && cp_req.opc1 == 3'h0 &&
                    (cp_req.crm == CMO_CRM_1 || cp_req.crm == CMO_CRM_2);
  assign barrier  = (cp_req.crm == CMO_CRM_10 && (cp_req.opc2 == 3'h4 || cp_req.opc2 == 3'h5)) ||
                    (cp_req.crm == CMO_CRM_5 && cp_req.opc2 == 3'h4);
  assign pa_read  = cp_req.crm == CMO_CRM_4 && cp_req.opc2 == 3'h0;
  assign apb_wr   = psel && penable && pwrite;
  assign apb_hit  = paddr == CMO_OFS_CFG || paddr == CMO_OFS_STAT ||
                    paddr == CMO_OFS_LAST || paddr == CMO_OFS_UNDEF;

  always_comb begin
    cmo_act_t a;
    logic     undef;
    a       = '0;
    undef   = 1'b0;
    next_st = st;
    next_st.rsp_valid = take;
    next_st.rsp_pa    = 1'b0;
    if (st.busy_cnt != 8'h00) begin
      next_st.busy_cnt = st.busy_cnt - 8'h01;
    end
    if (take) begin
      if (is_maint && !cp_req.write) begin
        undef = !pa_read;
        next_st.rsp_pa = pa_read && !cp_req.user;
        undef = undef || cp_req.user;
      end else if (is_maint && cp_req.user) begin
        undef = !barrier;
      end else if (is_maint) begin
        a.l2_bound = 1'b1;
        a.way      = od_way;
        a.set      = od_set;
        a.line     = od_line;
        case ({cp_req.crm, cp_req.opc2})
          {CMO_CRM_1, 3'h0}, {CMO_CRM_5, 3'h0}: begin
            a.valid = 1'b1;
            a.icache = 1'b1;
            a.whole = 1'b1;
            a.pred = cp_req.crm == CMO_CRM_5;
            next_st.busy_cnt = CMO_ICINV_CYCLES;
          end
          {CMO_CRM_1, 3'h6}, {CMO_CRM_5, 3'h6}: begin
            a.valid = 1'b1;
            a.pred = 1'b1;
            a.whole = 1'b1;
          end
          {CMO_CRM_5, 3'h1}: begin
            a.valid = 1'b1;
            a.icache = 1'b1;
          end
          {CMO_CRM_5, 3'h7}: begin
            a.valid = 1'b1;
            a.pred = 1'b1;
          end
          {CMO_CRM_6, 3'h1}, {CMO_CRM_6, 3'h2}: begin
            a.valid = 1'b1;
            a.dcache = 1'b1;
          end
          {CMO_CRM_10, 3'h1}, {CMO_CRM_10, 3'h2}: begin
            a.valid = 1'b1;
            a.dcache = 1'b1;
            a.clean = 1'b1;
          end
          {CMO_CRM_11, 3'h1}: begin
            a.valid = 1'b1;
            a.dcache = 1'b1;
            a.clean = 1'b1;
          end
          {CMO_CRM_14, 3'h1}, {CMO_CRM_14, 3'h2}: begin
            a.valid = 1'b1;
            a.dcache = 1'b1;
            a.clean = 1'b1;
          end
          default: begin
            a.valid = 1'b0;
          end
        endcase
        a.inval    = a.valid && cp_req.crm != CMO_CRM_10 && cp_req.crm != CMO_CRM_11;
        a.setway   = a.dcache && cp_req.opc2 == 3'h2;
        a.coherent = a.dcache && cp_req.crm != CMO_CRM_11;
        if (a.whole) begin
          a.set  = 9'h000;
          a.line = 27'h000_0000;
          a.way  = 2'h0;
        end else if (a.setway) begin
          a.line = 27'h000_0000;
        end else begin
          a.way = 2'h0;
          a.set = 9'h000;
        end
        a.l2_bound = a.valid;
        // Unlisted selects put no stale operand onto the action bus
        if (!a.valid) begin
          a = '0;
        end
      end else if (is_id) begin
        undef = cp_req.write || cp_req.user;
      end else begin
        undef = 1'b1;
      end
      next_st.last_sel = {cp_req.crm, cp_req.write, cp_req.opc2};
      if (undef) begin
        next_st.undef_count = st.undef_count + 16'h0001;
      end
      if (a.valid) begin
        next_st.op_count = st.op_count + 16'h0001;
      end
    end
    next_st.act       = a;
    next_st.rsp_undef = take && undef;
    next_st.pa_q      = pa_result;
    if (apb_wr && paddr == CMO_OFS_CFG) begin
      next_st.size_code = (pwdata[CMO_CFG_SIZE_LSB +: 3] > CMO_SIZE_MAX) ?
                          CMO_SIZE_MAX : pwdata[CMO_CFG_SIZE_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st           <= '0;
      st.size_code <= CMO_CFG_SIZE_RST;
    end else begin
      st <= next_st;
    end
  end

  // Zero-wait slave; unmapped offsets error and read zero
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      CMO_OFS_CFG:   prdata = {29'h0000_0000, st.size_code};
      CMO_OFS_STAT:  prdata = {st.op_count, 7'h00, od_rsvd, st.busy_cnt};
      CMO_OFS_LAST:  prdata = {24'h00_0000, st.last_sel};
      CMO_OFS_UNDEF: prdata = {16'h0000, st.undef_count};
      default:       prdata = 32'h0000_0000;
    endcase
  end

  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !apb_hit;
  assign rsp_valid = st.rsp_valid;
  assign rsp_undef = st.rsp_undef;
  assign rsp_rdata = st.rsp_pa ? st.pa_q : rom_q;
  assign act       = st.act;
  // Interrupts held off for the whole of a long invalidate
  assign irq_hold  = st.busy_cnt != 8'h00;

  rd_undef_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_maint && !cp_req.write && !pa_read |=> rsp_valid && rsp_undef)
    else $error("maintenance read not undefined");

  user_undef_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_maint && cp_req.write && cp_req.user && !barrier |=> rsp_undef && !act.valid)
    else $error("user maintenance not refused");

  icinv_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(irq_hold) |-> (irq_hold && !cp_ready) [*8] ##1 cp_ready)
    else $error("icache invalidate length wrong");

  whole_ops_a: assert property (@(posedge pclk) disable iff (!presetn)
    act.valid && act.whole |-> act.set == 9'h000 && act.line == 27'h000_0000)
    else $error("whole operation carries operand");

  setway_way_a: assert property (@(posedge pclk) disable iff (!presetn)
    act.valid && act.setway |-> act.way == $past(cp_req.wdata[31:30]))
    else $error("way field wrong");

  va_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    act.valid && !act.setway && !act.whole |-> act.line == $past(cp_req.wdata[31:5]))
    else $error("address operand wrong");

  icall_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_maint && cp_req.write && !cp_req.user && cp_req.crm == CMO_CRM_5 &&
    cp_req.opc2 == 3'h0 |=> act.valid && act.icache && act.pred && act.whole)
    else $error("icache invalidate all missing");

  id_rsv_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_id && !cp_req.write && cp_req.crm == CMO_CRM_1 &&
    cp_req.opc2 == CMO_OP2_ID_RSV |=> rsp_rdata == 32'h0000_0000)
    else $error("reserved feature not zero");

  l2_point_a: assert property (@(posedge pclk) disable iff (!presetn)
    act.valid |-> act.l2_bound && (!act.coherent || act.dcache))
    else $error("action not bound to level two");

  shr_icache_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_maint && cp_req.write && !cp_req.user && cp_req.crm == CMO_CRM_1 &&
    cp_req.opc2 == 3'h0 |=> act.valid && act.icache && act.whole && !act.pred && !cp_ready)
    else $error("shareable icache invalidate wrong");

  ic_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_maint && cp_req.write && !cp_req.user && cp_req.crm == CMO_CRM_5 &&
    cp_req.opc2 == 3'h1 |=> act.valid && act.icache && !act.whole && !act.pred && !act.coherent)
    else $error("icache line invalidate wrong");

  pred_all_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_maint && cp_req.write && !cp_req.user && cp_req.crm == CMO_CRM_5 &&
    cp_req.opc2 == 3'h6 |=> act.valid && act.pred && act.whole && !act.icache && cp_ready)
    else $error("predictor invalidate all wrong");

  pred_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_maint && cp_req.write && !cp_req.user && cp_req.crm == CMO_CRM_5 &&
    cp_req.opc2 == 3'h7 |=> act.valid && act.pred && !act.whole && !act.icache)
    else $error("predictor entry invalidate wrong");

  dc_inval_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_maint && cp_req.write && !cp_req.user && cp_req.crm == CMO_CRM_6 &&
    (cp_req.opc2 == 3'h1 || cp_req.opc2 == 3'h2) |=> act.valid && act.dcache && act.inval && !act.clean)
    else $error("dcache invalidate wrong");

  dc_clean_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_maint && cp_req.write && !cp_req.user && cp_req.crm == CMO_CRM_10 &&
    (cp_req.opc2 == 3'h1 || cp_req.opc2 == 3'h2) |=> act.valid && act.dcache && act.clean && !act.inval)
    else $error("dcache clean wrong");

  dc_unify_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_maint && cp_req.write && !cp_req.user && cp_req.crm == CMO_CRM_11 &&
    cp_req.opc2 == 3'h1 |=> act.valid && act.dcache && act.clean && !act.inval && !act.coherent)
    else $error("dcache clean to unification wrong");

  dc_cln_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_maint && cp_req.write && !cp_req.user && cp_req.crm == CMO_CRM_14 &&
    (cp_req.opc2 == 3'h1 || cp_req.opc2 == 3'h2) |=> act.valid && act.dcache && act.clean && act.inval)
    else $error("dcache clean and invalidate wrong");

  setway_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    act.valid && act.setway |-> (act.set >> (CMO_S_BASE + {1'b0, $past(st.size_code)})) == 9'h000)
    else $error("set field wider than size allows");

  va_noset_a: assert property (@(posedge pclk) disable iff (!presetn)
    act.valid && !act.setway && !act.whole |-> act.way == 2'h0 && act.set == 9'h000)
    else $error("address operation carries set or way");

  coh_point_a: assert property (@(posedge pclk) disable iff (!presetn)
    act.valid && act.dcache && !act.setway |-> act.coherent == ($past(cp_req.crm) != CMO_CRM_11))
    else $error("coherency point target wrong");

  isa_rsv_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_id && !cp_req.write && cp_req.crm == CMO_CRM_2 &&
    cp_req.opc2 > CMO_OP2_ISA_LAST |=> rsp_rdata == 32'h0000_0000)
    else $error("reserved attribute not zero");

  pa_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_maint && !cp_req.write && !cp_req.user &&
    pa_read |=> rsp_valid && !rsp_undef && rsp_rdata == $past(pa_result))
    else $error("address result read refused");

  user_barrier_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && is_maint && cp_req.write && cp_req.user &&
    barrier |=> rsp_valid && !rsp_undef && !act.valid)
    else $error("user barrier refused");
endmodule

// >>> sim/cmo_pipe_model.sv
// Pipeline-side model that issues coprocessor transfers.
// Assumes issue is called right after a rising pclk edge.
`timescale 1ns/1ps
module cmo_pipe_model
  import cmo_pkg::*;
(
  // Clock
  input  wire logic pclk,
  // Transfer
  input  wire logic cp_ready,
  output logic      cp_valid,
  output cmo_req_t  cp_req
);
  initial begin
    cp_valid = 1'b0;
    cp_req   = '0;
  end

  // Released fields are inverted, so a stale value never passes for a held one
  task automatic issue(input cmo_req_t r);
    cp_valid <= 1'b1;
    cp_req   <= r;
    @(posedge pclk);
    while (cp_ready !== 1'b1) begin
      @(posedge pclk);
    end
    cp_valid <= 1'b0;
    cp_req   <= ~r;
  endtask
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the cache maintenance decoder.
// Assumes the default feature values of the id rom.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; $display("Error %s exp %h got %h", nm, e, g); end end
module tb_top
  import cmo_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        cp_valid, cp_ready, rsp_valid, rsp_undef, irq_hold;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pa_result, rsp_rdata;
  logic [2:0]  code;
  cmo_req_t    cp_req;
  cmo_act_t    act;
  int          errors, n_tests, n_undef, n_act, run;
  localparam logic [31:0] FEAT_V [8] = '{32'h11, 32'h12, 32'h13, 32'h0, 32'h21, 32'h22, 32'h23, 32'h24};
  localparam logic [31:0] ISA_V  [5] = '{32'h31, 32'h32, 32'h33, 32'h34, 32'h35};
  localparam logic [6:0]  OPS   [16] = '{7'h08, 7'h0E, 7'h28, 7'h29, 7'h2C, 7'h2E, 7'h2F, 7'h31,
                                        7'h32, 7'h51, 7'h52, 7'h54, 7'h55, 7'h59, 7'h71, 7'h72};

  cmo_maint u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cp_valid(cp_valid), .cp_ready(cp_ready), .cp_req(cp_req), .pa_result(pa_result),
    .rsp_valid(rsp_valid), .rsp_undef(rsp_undef), .rsp_rdata(rsp_rdata), .act(act), .irq_hold(irq_hold));
  cmo_pipe_model u_pipe (.pclk(pclk), .cp_ready(cp_ready), .cp_valid(cp_valid), .cp_req(cp_req));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Flags f: icache dcache pred clean inval whole setway coherent coherent_known
  function automatic void exp_op(input cmo_req_t r, input logic [2:0] c,
                                 output cmo_act_t e, output cmo_act_t m, output logic u);
    logic [6:0] k;
    logic [8:0] f;
    int         s;
    k = {r.crm, r.opc2};
    s = 5 + ((c > CMO_SIZE_MAX) ? 4 : int'(c));
    e = '0;
    m = '1;
    u = 1'b0;
    case (k)
      7'h08: f = 9'b100011000;
      7'h28: f = 9'b101011000;
      7'h0E, 7'h2E: f = 9'b001011000;
      7'h29: f = 9'b100010001;
      7'h2F: f = 9'b001010000;
      7'h31: f = 9'b010010011;
      7'h32: f = 9'b010010100;
      7'h51: f = 9'b010100011;
      7'h52: f = 9'b010100100;
      7'h59: f = 9'b010100001;
      7'h71: f = 9'b010110011;
      7'h72: f = 9'b010110100;
      default: f = '0;
    endcase
    if (r.crn == CMO_CRN_MAINT) begin
      if (!r.write) u = r.user || k != 7'h20;
      else if (r.user) u = !(k inside {7'h2C, 7'h54, 7'h55});
      else if (f != 0) begin
        {e.icache, e.dcache, e.pred, e.clean, e.inval, e.whole, e.setway, e.coherent} = f[8:1];
        e.valid = 1'b1;
        e.l2_bound = 1'b1;
        m.coherent = f[0];
        if (f[2]) begin
          e.way = r.wdata[31:30];
          e.set = 9'((r.wdata >> 5) & ((32'h1 << s) - 1));
        end
        else if (!f[3]) e.line = r.wdata[31:5];
      end
    end
    else u = r.write || r.user || r.crn != CMO_CRN_ID;
  endfunction

  task automatic do_op(input cmo_req_t r);
    cmo_act_t    e, m;
    logic        u;
    logic [31:0] pa, d;
    pa = $urandom();
    exp_op(r, code, e, m, u);
    d = (r.crn == CMO_CRN_MAINT) ? pa : (r.crm == CMO_CRM_1) ? FEAT_V[r.opc2] :
        (r.opc2 <= CMO_OP2_ISA_LAST) ? ISA_V[r.opc2] : 32'h0;
    pa_result <= pa;
    u_pipe.issue(r);
    @(negedge pclk);
    `CHK("rsp_valid", 1'b1, rsp_valid)
    `CHK("rsp_undef", u, rsp_undef)
    if (!u && !r.write) `CHK("rsp_rdata", d, rsp_rdata)
    `CHK("act", e & m, act & m)
    n_undef += int'(u);
    n_act += int'(e.valid);
    @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_code(input logic [2:0] c);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, CMO_OFS_CFG, 32'(c) << CMO_CFG_SIZE_LSB, rd, er);
    code = c;
    @(posedge pclk);
  endtask

  task stop_test;
    $display("errors=%0d comparisons=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Busy window length after a whole icache invalidate
  always @(posedge pclk) begin
    if (presetn === 1'b1 && cp_ready === 1'b0) begin
      run++;
      if (run == 3) `CHK("irq_hold", 1'b1, irq_hold)
    end
    else if (run != 0) begin
      `CHK("busy_len", int'(CMO_ICINV_CYCLES), run)
      run = 0;
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    stop_test;
  end

  initial begin
    cmo_req_t    r;
    logic [31:0] rd;
    logic        er;
    int          k;
    {presetn, psel, penable, pwrite, paddr, pwdata, pa_result} = '0;
    {errors, n_tests, n_undef, n_act, run} = '0;
    code = CMO_CFG_SIZE_RST;
    void'($urandom(32'h1a13afdf));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h010, 32'h0, rd, er);
    `CHK("unmapped_err", 1'b1, er)
    `CHK("unmapped_rd", 32'h0, rd)
    @(posedge pclk);
    // Every maintenance code at every size, plus one clamped size
    for (int c = 0; c < 6; c++) begin
      set_code(3'(c));
      foreach (OPS[i]) begin
        r = '0;
        r.write = 1'b1;
        r.crn = CMO_CRN_MAINT;
        {r.crm, r.opc2} = OPS[i];
        r.wdata = c[0] ? 32'hFFFF_FFFF : $urandom();
        do_op(r);
      end
    end
    for (int i = 0; i < 18; i++) begin
      r = '0;
      r.crn = (i < 16) ? CMO_CRN_ID : CMO_CRN_MAINT;
      r.crm = (i < 8) ? CMO_CRM_1 : (i < 16) ? CMO_CRM_2 : CMO_CRM_4;
      r.opc2 = 3'(i);
      r.user = (i == 17);
      do_op(r);
    end
    for (int i = 0; i < 400; i++) begin
      if (i % 100 == 0) set_code(3'($urandom_range(0, 7)));
      r = '0;
      k = $urandom_range(0, 9);
      r.write = 1'($urandom_range(0, 1));
      r.user = ($urandom_range(0, 3) == 0);
      r.crn = (k < 7) ? CMO_CRN_MAINT : (k < 9) ? CMO_CRN_ID : 4'h9;
      r.crm = (r.crn == CMO_CRN_ID) ? (k[0] ? CMO_CRM_1 : CMO_CRM_2) : OPS[$urandom_range(0, 15)][6:3];
      r.opc2 = 3'($urandom_range(0, 7));
      r.wdata = $urandom();
      do_op(r);
    end
    apb(1'b0, CMO_OFS_UNDEF, 32'h0, rd, er);
    `CHK("undef_count", 16'(n_undef), rd[15:0])
    @(posedge pclk);
    apb(1'b0, CMO_OFS_STAT, 32'h0, rd, er);
    `CHK("action_count", 16'(n_act), rd[31:16])
    @(posedge pclk);
    apb(1'b0, CMO_OFS_LAST, 32'h0, rd, er);
    `CHK("last_req", {r.crm, r.write, r.opc2}, rd[7:0])
    @(posedge pclk);
    apb(1'b0, CMO_OFS_CFG, 32'h0, rd, er);
    `CHK("size_code", (code > CMO_SIZE_MAX) ? CMO_SIZE_MAX : code, rd[2:0])
    stop_test;
  end
endmodule
